// ---- tsm_mac.sv ----
/*
  Tri-speed Ethernet MAC core: transmit section on the system clock, receive
  section on the PHY receive clock, CRC engines, collision retry and stats.
  Assumes a client transmit FIFO showing its head byte (first-word fall-through)
  and a client receive FIFO that takes one byte per write strobe and discards
  a frame whose end is marked bad. In 10/100 mode clk_in must be the PHY
  transmit clock; the receive clock from the PHY runs continuously.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tsm_regs.svh"

module tsm_mac
  import tsm_pkg::*;
#(
  parameter tsm_build_t  BUILD        = TSM_CLASSIC,
  parameter logic [47:0] STATION_ADDR = 48'h000000000000,
  parameter logic        ACCEPT_ALL   = 1'b0
) (
  input  wire logic           clk_in,
  input  wire logic           reset_n_in,
  input  wire logic           rx_clk_in,
  input  wire logic           speed_gbit_in,
  input  wire logic           full_duplex_in,
  input  wire logic           tx_clk_en_in,
  input  wire logic           rx_clk_en_in,
  input  wire logic           tx_fifo_avail_in,
  input  wire tsm_tx_byte_t   tx_fifo_head_in,
  output logic                tx_fifo_rd_out,
  output logic                tx_done_out,
  output logic                tx_abort_out,
  output tsm_gmii_tx_t        gmii_tx_out,
  input  wire tsm_gmii_rx_t   gmii_rx_in,
  input  wire logic           col_in,
  input  wire logic           crs_in,
  output tsm_rx_client_t      rx_client_out,
  output tsm_rx_stat_t        rx_stat_out,
  output logic                rx_stat_vld_out,
  output logic                gbit_en_out
);

  tsm_sys_state_t sys_r;
  tsm_sys_state_t sys_nxt;
  tsm_rx_state_t  rx_r;
  tsm_rx_state_t  rx_nxt;

  logic        tx_adv;
  logic        tx_byte_mode;
  logic        half_dup;
  logic        tx_start;
  logic        tx_new;
  logic        tx_en;
  logic        tx_last;
  logic        tx_rd;
  logic [7:0]  nb;
  logic        crc_tx_init;
  logic        crc_tx_upd;
  logic [31:0] crc_tx;
  logic [31:0] tx_fcs;

  logic        rx_adv;
  logic        rx_byte_mode;
  logic        bv;
  logic        dv_end;
  logic [7:0]  b;
  logic        acc_now;
  logic        crc_rx_init;
  logic        crc_rx_upd;
  logic        crc_rx_ok;

  function automatic logic [9:0] backoff_mask(input logic [4:0] n);
    logic [4:0] k;
    k = (n > `TSM_BACKOFF_EXP) ? `TSM_BACKOFF_EXP : n;
    return 10'((11'h001 << k) - 11'h001);
  endfunction

  function automatic logic addr_match(input logic [47:0] d);
    return ACCEPT_ALL || (d == STATION_ADDR) || d[40];
  endfunction

  // Gigabit-only and PCS builds are byte-wide always; half duplex only at 10/100
  assign tx_byte_mode = (BUILD != TSM_CLASSIC) || sys_r.gbit;
  assign half_dup     = (BUILD == TSM_CLASSIC) && !sys_r.gbit && !full_duplex_in;
  assign tx_adv       = (BUILD == TSM_PCS) ? tx_clk_en_in : 1'b1;
  assign tx_fcs       = ~crc_tx;

  // Transmit section, system clock domain
  always_comb begin
    sys_nxt     = sys_r;
    tx_start    = 1'b0;
    tx_new      = 1'b0;
    tx_en       = 1'b0;
    tx_last     = 1'b0;
    tx_rd       = 1'b0;
    nb          = sys_r.cur;
    crc_tx_init = 1'b0;
    crc_tx_upd  = 1'b0;
    sys_nxt.done     = 1'b0;
    sys_nxt.abort    = 1'b0;
    sys_nxt.stat_vld = 1'b0;
    sys_nxt.lfsr = {sys_r.lfsr[14:0], ~(sys_r.lfsr[15] ^ sys_r.lfsr[14]
                                        ^ sys_r.lfsr[12] ^ sys_r.lfsr[3])};
    sys_nxt.gbit = (BUILD != TSM_CLASSIC) || sys_r.spd_s2;
    if (tx_adv) begin
      if (sys_r.half) begin
        sys_nxt.gmii.txd = {4'h0, sys_r.cur[7:4]};
        sys_nxt.half     = 1'b0;
      end else begin
        if (half_dup && sys_r.col_s2 && sys_r.gmii.tx_en
            && (sys_r.st inside {TX_PRE, TX_DATA, TX_FCS})) begin
          // Past the kept bytes the frame cannot be replayed, so it is given up
          if (sys_r.pos > `TSM_REPLAY_BYTES || sys_r.attempt == `TSM_ATTEMPT_LAST) begin
            sys_nxt.st      = TX_IFG;
            sys_nxt.cnt     = 16'h0000;
            sys_nxt.abort   = 1'b1;
            sys_nxt.attempt = 5'h00;
          end else begin
            sys_nxt.st      = TX_JAM;
            sys_nxt.cnt     = 16'h0001;
            sys_nxt.attempt = sys_r.attempt + 5'h01;
            nb              = `TSM_JAM_BYTE;
            tx_en           = 1'b1;
          end
        end else begin
          unique case (sys_r.st)
            TX_IDLE: begin
              if (tx_fifo_avail_in && !(half_dup && sys_r.crs_s2)) begin
                tx_start = 1'b1;
                tx_new   = 1'b1;
              end
            end
            TX_PRE: begin
              tx_en = 1'b1;
              if (sys_r.cnt < `TSM_PRE_CNT) begin
                nb          = `TSM_PRE_BYTE;
                sys_nxt.cnt = sys_r.cnt + 16'h0001;
              end else begin
                nb         = `TSM_SFD_BYTE;
                sys_nxt.st = TX_DATA;
              end
            end
            TX_DATA: begin
              tx_en = 1'b1;
              if (sys_r.pos < sys_r.len) begin
                nb      = sys_r.buff[sys_r.pos[5:0]];
                tx_last = sys_r.eof_seen && (sys_r.pos + 7'h01 == sys_r.len);
              end else begin
                nb      = tx_fifo_head_in.data;
                tx_rd   = 1'b1;
                tx_last = tx_fifo_head_in.eof;
                if (sys_r.pos < `TSM_REPLAY_BYTES) begin
                  sys_nxt.buff[sys_r.pos[5:0]] = nb;
                  sys_nxt.len                  = sys_r.pos + 7'h01;
                  sys_nxt.eof_seen             = tx_last;
                end
              end
              crc_tx_upd = 1'b1;
              if (sys_r.pos != `TSM_POS_MAX) begin
                sys_nxt.pos = sys_r.pos + 7'h01;
              end
              if (tx_last) begin
                sys_nxt.st  = TX_FCS;
                sys_nxt.cnt = 16'h0000;
              end
            end
            TX_FCS: begin
              tx_en = 1'b1;
              nb    = 8'(tx_fcs >> {sys_r.cnt[1:0], 3'b000});
              if (sys_r.cnt == `TSM_FCS_LAST) begin
                sys_nxt.st      = TX_IFG;
                sys_nxt.cnt     = 16'h0000;
                sys_nxt.done    = 1'b1;
                sys_nxt.attempt = 5'h00;
              end else begin
                sys_nxt.cnt = sys_r.cnt + 16'h0001;
              end
            end
            TX_JAM: begin
              if (sys_r.cnt < `TSM_JAM_CNT) begin
                tx_en       = 1'b1;
                nb          = `TSM_JAM_BYTE;
                sys_nxt.cnt = sys_r.cnt + 16'h0001;
              end else begin
                // Backoff in slot times of 64 clock cycles, which are nibble periods at 10/100
                sys_nxt.st  = TX_BACKOFF;
                sys_nxt.cnt = {sys_r.lfsr[9:0] & backoff_mask(sys_r.attempt),
                               `TSM_SLOT_SHIFT};
              end
            end
            TX_BACKOFF: begin
              if (sys_r.cnt != 16'h0000) begin
                sys_nxt.cnt = sys_r.cnt - 16'h0001;
              end else if (!sys_r.crs_s2) begin
                tx_start = 1'b1;
              end
            end
            TX_IFG: begin
              if (sys_r.cnt + 16'h0001 == `TSM_IFG_BYTES) begin
                sys_nxt.st = TX_IDLE;
              end else begin
                sys_nxt.cnt = sys_r.cnt + 16'h0001;
              end
            end
          endcase
        end
        if (tx_start) begin
          sys_nxt.st  = TX_PRE;
          sys_nxt.cnt = 16'h0001;
          sys_nxt.pos = 7'h00;
          nb          = `TSM_PRE_BYTE;
          tx_en       = 1'b1;
          crc_tx_init = 1'b1;
        end
        if (tx_new) begin
          sys_nxt.len      = 7'h00;
          sys_nxt.eof_seen = 1'b0;
          sys_nxt.attempt  = 5'h00;
        end
        sys_nxt.cur        = nb;
        sys_nxt.gmii.tx_en = tx_en;
        sys_nxt.gmii.tx_er = 1'b0;
        sys_nxt.gmii.txd   = tx_byte_mode ? nb : {4'h0, nb[3:0]};
        sys_nxt.half       = !tx_byte_mode && tx_en;
      end
    end
    // Statistics arrive from the receive domain by toggle handshake
    if (sys_r.tgl_s2 != sys_r.tgl_s3) begin
      sys_nxt.stat     = rx_r.stat;
      sys_nxt.stat_vld = 1'b1;
    end
    if (!reset_n_in) begin
      sys_nxt      = '0;
      sys_nxt.lfsr = `TSM_LFSR_SEED;
      tx_rd        = 1'b0;
      crc_tx_init  = 1'b0;
      crc_tx_upd   = 1'b0;
    end
    // Synchronisers keep running through reset so no false edge follows release
    sys_nxt.spd_s1 = speed_gbit_in;
    sys_nxt.spd_s2 = sys_r.spd_s1;
    sys_nxt.col_s1 = col_in;
    sys_nxt.col_s2 = sys_r.col_s1;
    sys_nxt.crs_s1 = crs_in;
    sys_nxt.crs_s2 = sys_r.crs_s1;
    sys_nxt.tgl_s1 = rx_r.tgl;
    sys_nxt.tgl_s2 = sys_r.tgl_s1;
    sys_nxt.tgl_s3 = sys_r.tgl_s2;
  end

  always_ff @(posedge clk_in) begin
    sys_r <= sys_nxt;
  end

  tsm_crc u_crc_tx (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .init_in        (crc_tx_init),
    .upd_in         (crc_tx_upd),
    .data_in        (nb),
    .crc_out        (crc_tx),
    .residue_ok_out ()
  );

  // Receive section, PHY receive clock domain
  assign rx_byte_mode = (BUILD != TSM_CLASSIC) || rx_r.spd_s2;
  assign rx_adv       = (BUILD == TSM_PCS) ? rx_r.en2 : 1'b1;

  always_comb begin
    rx_nxt      = rx_r;
    bv          = 1'b0;
    b           = rx_r.pin2.rxd;
    acc_now     = rx_r.accept;
    crc_rx_init = 1'b0;
    crc_rx_upd  = 1'b0;
    dv_end      = rx_adv && !rx_r.pin2.rx_dv;
    rx_nxt.cli.wr  = 1'b0;
    rx_nxt.cli.sof = 1'b0;
    rx_nxt.cli.eof = 1'b0;
    // Good qualifies only the closing write, so it is a pulse like eof
    rx_nxt.cli.good = 1'b0;
    if (rx_adv && rx_r.pin2.rx_dv) begin
      if (rx_byte_mode) begin
        bv = 1'b1;
      end else if (rx_r.half) begin
        b           = {rx_r.pin2.rxd[3:0], rx_r.nib};
        bv          = 1'b1;
        rx_nxt.half = 1'b0;
      end else begin
        rx_nxt.nib  = rx_r.pin2.rxd[3:0];
        rx_nxt.half = 1'b1;
      end
    end
    if (dv_end) begin
      rx_nxt.half = 1'b0;
    end
    unique case (rx_r.st)
      RX_IDLE: begin
        if (bv && b == `TSM_PRE_BYTE) begin
          rx_nxt.st = RX_PRE;
        end
      end
      RX_PRE: begin
        if (dv_end) begin
          rx_nxt.st = RX_IDLE;
        end else if (bv && b == `TSM_SFD_BYTE) begin
          rx_nxt.st       = RX_FRAME;
          rx_nxt.cnt      = 16'h0000;
          rx_nxt.err      = 1'b0;
          rx_nxt.accept   = 1'b0;
          rx_nxt.vlan     = 1'b0;
          rx_nxt.sof_pend = 1'b1;
          crc_rx_init     = 1'b1;
        end else if (bv && b != `TSM_PRE_BYTE) begin
          rx_nxt.st = RX_SKIP;
        end
      end
      RX_FRAME: begin
        if (rx_adv && rx_r.pin2.rx_dv && rx_r.pin2.rx_er) begin
          rx_nxt.err = 1'b1;
        end
        if (dv_end) begin
          rx_nxt.good = crc_rx_ok && !rx_r.err && (rx_r.cnt >= `TSM_MIN_FRAME);
          rx_nxt.stat.byte_cnt = rx_r.cnt;
          rx_nxt.stat.crc_ok   = crc_rx_ok;
          rx_nxt.stat.runt     = rx_r.cnt < `TSM_MIN_FRAME;
          rx_nxt.stat.addr_ok  = rx_r.accept;
          rx_nxt.stat.bcast    = rx_r.da == `TSM_BCAST_DA;
          rx_nxt.stat.mcast    = rx_r.da[40];
          rx_nxt.stat.pause    = (rx_r.da == `TSM_PAUSE_DA)
                                 && (rx_r.ltype == `TSM_TYPE_PAUSE);
          rx_nxt.stat.vlan     = rx_r.vlan;
          rx_nxt.stat.phy_err  = rx_r.err;
          rx_nxt.tgl           = !rx_r.tgl;
          // Fewer than seven bytes never reached the client: nothing to close
          rx_nxt.st    = (rx_r.accept && rx_r.cnt > `TSM_DA_BYTES) ? RX_DRAIN : RX_IDLE;
          rx_nxt.drain = 1'b0;
        end else if (bv) begin
          crc_rx_upd = 1'b1;
          if (rx_r.cnt != `TSM_CNT_MAX) begin
            rx_nxt.cnt = rx_r.cnt + 16'h0001;
          end
          rx_nxt.line = {rx_r.line[4:0], b};
          if (rx_r.cnt < `TSM_DA_BYTES) begin
            rx_nxt.da = {rx_r.da[39:0], b};
          end
          if (rx_r.cnt == `TSM_TYPE_POS || rx_r.cnt == `TSM_TYPE_POS + 16'h0001
              || (rx_r.vlan && (rx_r.cnt == `TSM_VLAN_TYPE_POS
                                || rx_r.cnt == `TSM_VLAN_TYPE_POS + 16'h0001))) begin
            rx_nxt.ltype = {rx_r.ltype[7:0], b};
          end
          if (rx_r.cnt == `TSM_VLAN_CHK_POS && rx_r.ltype == `TSM_TYPE_VLAN) begin
            rx_nxt.vlan = 1'b1;
          end
          if (rx_r.cnt == `TSM_DA_BYTES) begin
            acc_now       = addr_match(rx_r.da);
            rx_nxt.accept = acc_now;
          end
          if (rx_r.cnt >= `TSM_DA_BYTES && acc_now) begin
            rx_nxt.cli.data = rx_r.line[5];
            rx_nxt.cli.wr   = 1'b1;
            rx_nxt.cli.sof  = rx_r.sof_pend;
            rx_nxt.sof_pend = 1'b0;
          end
        end
      end
      RX_DRAIN: begin
        // The youngest four bytes are the check sequence and are withheld
        rx_nxt.cli.data = rx_r.line[5];
        rx_nxt.cli.wr   = 1'b1;
        rx_nxt.line     = {rx_r.line[4:0], 8'h00};
        rx_nxt.drain    = 1'b1;
        if (rx_r.drain) begin
          rx_nxt.cli.eof  = 1'b1;
          rx_nxt.cli.good = rx_r.good;
          rx_nxt.st       = RX_IDLE;
        end
      end
      RX_SKIP: begin
        if (dv_end) begin
          rx_nxt.st = RX_IDLE;
        end
      end
    endcase
    if (!rx_r.rst_s2) begin
      rx_nxt      = '0;
      crc_rx_init = 1'b0;
      crc_rx_upd  = 1'b0;
    end
    rx_nxt.rst_s1 = reset_n_in;
    rx_nxt.rst_s2 = rx_r.rst_s1;
    rx_nxt.spd_s1 = sys_r.gbit;
    rx_nxt.spd_s2 = rx_r.spd_s1;
    rx_nxt.pin1   = gmii_rx_in;
    rx_nxt.pin2   = rx_r.pin1;
    rx_nxt.en1    = rx_clk_en_in;
    rx_nxt.en2    = rx_r.en1;
  end

  always_ff @(posedge rx_clk_in) begin
    rx_r <= rx_nxt;
  end

  tsm_crc u_crc_rx (
    .clk_in         (rx_clk_in),
    .reset_n_in     (rx_r.rst_s2),
    .init_in        (crc_rx_init),
    .upd_in         (crc_rx_upd),
    .data_in        (b),
    .crc_out        (),
    .residue_ok_out (crc_rx_ok)
  );

  assign tx_fifo_rd_out  = tx_rd;
  assign tx_done_out     = sys_r.done;
  assign tx_abort_out    = sys_r.abort;
  assign gmii_tx_out     = sys_r.gmii;
  assign rx_client_out   = rx_r.cli;
  assign rx_stat_out     = sys_r.stat;
  assign rx_stat_vld_out = sys_r.stat_vld;
  assign gbit_en_out     = sys_r.gbit;

endmodule
`default_nettype wire

// ---- tsm_regs.svh ----
/*
  Constants of the tri-speed MAC: frame bytes, counts and CRC figures.
  Assumes inclusion by the package users only; definitions, no logic.
*/
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH

`define TSM_PRE_BYTE       8'h55
`define TSM_SFD_BYTE       8'hD5
`define TSM_JAM_BYTE       8'h55
`define TSM_PRE_CNT        16'h0007
`define TSM_JAM_CNT        16'h0004
`define TSM_IFG_BYTES      16'h000C
`define TSM_FCS_LAST       16'h0003
`define TSM_DA_BYTES       16'h0006
`define TSM_TYPE_POS       16'h000C
`define TSM_VLAN_CHK_POS   16'h000E
`define TSM_VLAN_TYPE_POS  16'h0010
`define TSM_MIN_FRAME      16'h0040
`define TSM_CNT_MAX        16'hFFFF
`define TSM_REPLAY_BYTES   7'h40
`define TSM_POS_MAX        7'h7F
`define TSM_ATTEMPT_LAST   5'h0F
`define TSM_BACKOFF_EXP    5'h0A
`define TSM_SLOT_SHIFT     6'h00
`define TSM_CRC_INIT       32'hFFFFFFFF
`define TSM_CRC_POLY       32'hEDB88320
`define TSM_CRC_RESIDUE    32'hDEBB20E3
`define TSM_PAUSE_DA       48'h0180C2000001
`define TSM_BCAST_DA       48'hFFFFFFFFFFFF
`define TSM_TYPE_PAUSE     16'h8808
`define TSM_TYPE_VLAN      16'h8100
`define TSM_LFSR_SEED      16'h0000

`endif

// ---- tsm_pkg.sv ----
/*
  Types of the tri-speed MAC: build options, state machines, pin and client bundles.
  Assumes nothing; compiled before every module.
*/
package tsm_pkg;

  typedef enum logic [1:0] {TSM_CLASSIC, TSM_GBIT_ONLY, TSM_PCS} tsm_build_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_PRE, TX_DATA, TX_FCS, TX_JAM, TX_BACKOFF, TX_IFG
  } tsm_tx_st_t;

  typedef enum logic [2:0] {RX_IDLE, RX_PRE, RX_FRAME, RX_DRAIN, RX_SKIP} tsm_rx_st_t;

  typedef struct packed {
    logic [7:0] txd;
    logic       tx_en;
    logic       tx_er;
  } tsm_gmii_tx_t;

  typedef struct packed {
    logic [7:0] rxd;
    logic       rx_dv;
    logic       rx_er;
  } tsm_gmii_rx_t;

  typedef struct packed {
    logic [7:0] data;
    logic       eof;
  } tsm_tx_byte_t;

  typedef struct packed {
    logic [7:0] data;
    logic       wr;
    logic       sof;
    logic       eof;
    logic       good;
  } tsm_rx_client_t;

  typedef struct packed {
    logic [15:0] byte_cnt;
    logic        crc_ok;
    logic        runt;
    logic        addr_ok;
    logic        bcast;
    logic        mcast;
    logic        pause;
    logic        vlan;
    logic        phy_err;
  } tsm_rx_stat_t;

  typedef struct packed {
    logic [31:0] crc;
  } tsm_crc_state_t;

  typedef struct packed {
    logic                spd_s1;
    logic                spd_s2;
    logic                col_s1;
    logic                col_s2;
    logic                crs_s1;
    logic                crs_s2;
    logic                tgl_s1;
    logic                tgl_s2;
    logic                tgl_s3;
    logic                gbit;
    tsm_tx_st_t          st;
    logic                half;
    logic [7:0]          cur;
    logic [15:0]         cnt;
    logic [6:0]          pos;
    logic [6:0]          len;
    logic                eof_seen;
    logic [4:0]          attempt;
    logic [15:0]         lfsr;
    logic [63:0][7:0]    buff;
    tsm_gmii_tx_t        gmii;
    logic                done;
    logic                abort;
    tsm_rx_stat_t        stat;
    logic                stat_vld;
  } tsm_sys_state_t;

  typedef struct packed {
    logic                rst_s1;
    logic                rst_s2;
    logic                spd_s1;
    logic                spd_s2;
    tsm_gmii_rx_t        pin1;
    tsm_gmii_rx_t        pin2;
    logic                en1;
    logic                en2;
    tsm_rx_st_t          st;
    logic                half;
    logic [3:0]          nib;
    logic [15:0]         cnt;
    logic [5:0][7:0]     line;
    logic [47:0]         da;
    logic [15:0]         ltype;
    logic                accept;
    logic                vlan;
    logic                err;
    logic                sof_pend;
    logic                drain;
    logic                good;
    tsm_rx_client_t      cli;
    tsm_rx_stat_t        stat;
    logic                tgl;
  } tsm_rx_state_t;

endpackage

// ---- tsm_crc32.sv ----
/*
  Ethernet CRC-32 engine, one byte per update, reflected form.
  Assumes init and update are never asked in the same cycle; init wins if they are.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tsm_regs.svh"

module tsm_crc
  import tsm_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        init_in,
  input  wire logic        upd_in,
  input  wire logic [7:0]  data_in,
  output logic      [31:0] crc_out,
  output logic             residue_ok_out
);

  tsm_crc_state_t crc_r;
  tsm_crc_state_t crc_nxt;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `TSM_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  always_comb begin
    crc_nxt = crc_r;
    if (!reset_n_in || init_in) begin
      crc_nxt.crc = `TSM_CRC_INIT;
    end else if (upd_in) begin
      crc_nxt.crc = crc_byte(crc_r.crc, data_in);
    end
  end

  always_ff @(posedge clk_in) begin
    crc_r <= crc_nxt;
  end

  assign crc_out        = crc_r.crc;
  // Running over the check sequence too leaves a fixed residue on a clean frame
  assign residue_ok_out = (crc_r.crc == `TSM_CRC_RESIDUE);

endmodule
`default_nettype wire

// ---- tsm_mac_chk.sv ----
/*
  Port assertions of the MAC, bound to every tsm_mac instance.
  Assumes gigabit full-duplex traffic in the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module tsm_mac_chk
  import tsm_pkg::*;
(
  input wire logic           clk_in,
  input wire logic           reset_n_in,
  input wire logic           rx_clk_in,
  input wire logic           full_duplex_in,
  input wire logic           tx_fifo_avail_in,
  input wire tsm_tx_byte_t   tx_fifo_head_in,
  input wire logic           tx_fifo_rd_out,
  input wire logic           tx_done_out,
  input wire tsm_gmii_tx_t   gmii_tx_out,
  input wire tsm_rx_client_t rx_client_out,
  input wire logic           rx_stat_vld_out
);
  property p_pre;
    @(posedge clk_in) disable iff (!reset_n_in) $rose(gmii_tx_out.tx_en) |->
      gmii_tx_out.txd == 8'h55 ##7 gmii_tx_out.tx_en && gmii_tx_out.txd == 8'hD5;
  endproperty
  a_pre: assert property (p_pre) else $error("bad preamble");
  property p_rd;
    @(posedge clk_in) disable iff (!reset_n_in)
      tx_fifo_rd_out |-> tx_fifo_avail_in && gmii_tx_out.tx_en;
  endproperty
  a_rd: assert property (p_rd) else $error("read without packet");
  property p_fcs;
    @(posedge clk_in) disable iff (!reset_n_in)
      tx_fifo_rd_out && tx_fifo_head_in.eof && full_duplex_in |-> ##5 tx_done_out;
  endproperty
  a_fcs: assert property (p_fcs) else $error("check bytes miscounted");
  property p_done;
    @(posedge clk_in) disable iff (!reset_n_in)
      tx_done_out |-> gmii_tx_out.tx_en ##1 !gmii_tx_out.tx_en && !tx_done_out;
  endproperty
  a_done: assert property (p_done) else $error("done misplaced");
  property p_rst;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(reset_n_in) |-> gmii_tx_out == '0 && !tx_done_out && !rx_stat_vld_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active in reset");
  property p_good;
    @(posedge rx_clk_in) disable iff (!reset_n_in)
      rx_client_out.good |-> rx_client_out.wr && rx_client_out.eof;
  endproperty
  a_good: assert property (p_good) else $error("good off frame end");
  property p_sof;
    @(posedge rx_clk_in) disable iff (!reset_n_in)
      rx_client_out.sof |-> rx_client_out.wr && !rx_client_out.eof;
  endproperty
  a_sof: assert property (p_sof) else $error("start without write");
  property p_gap;
    @(posedge rx_clk_in) disable iff (!reset_n_in)
      rx_client_out.eof |=> !rx_client_out.wr [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("write after frame end");
  property p_stat;
    @(posedge clk_in) disable iff (!reset_n_in) rx_stat_vld_out |=> !rx_stat_vld_out;
  endproperty
  a_stat: assert property (p_stat) else $error("stat pulse too long");
endmodule
bind tsm_mac tsm_mac_chk u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .rx_clk_in(rx_clk_in), .full_duplex_in(full_duplex_in),
  .tx_fifo_avail_in(tx_fifo_avail_in), .tx_fifo_head_in(tx_fifo_head_in),
  .tx_fifo_rd_out(tx_fifo_rd_out), .tx_done_out(tx_done_out), .gmii_tx_out(gmii_tx_out),
  .rx_client_out(rx_client_out), .rx_stat_vld_out(rx_stat_vld_out));
`default_nettype wire

// ---- tsm_phy_model.sv ----
/*
  Behavioural PHY: receive clock and GMII byte frames.
  Assumes the caller supplies the bytes after the delimiter.
*/
`timescale 1ns/10ps
`default_nettype none
module tsm_phy_model
  import tsm_pkg::*;
(
  output logic         rx_clk_out,
  output tsm_gmii_rx_t gmii_out
);
  initial begin
    rx_clk_out = 1'b0;
    gmii_out = '0;
    // Runs between frames: the receive side needs it to leave reset
    forever #32 rx_clk_out = ~rx_clk_out;
  end
  task automatic send(input logic [7:0] b [0:127], input int n);
    for (int i = 0; i < n + 8; i++) begin
      @(posedge rx_clk_out);
      gmii_out <= '{i < 7 ? 8'h55 : i == 7 ? 8'hD5 : b[i-8], 1'b1, 1'b0};
    end
    @(posedge rx_clk_out);
    gmii_out <= '{~gmii_out.rxd, 1'b0, 1'b0};
  endtask
endmodule
`default_nettype wire

// ---- tb_tsm_mac.sv ----
/*
  Self-checking bench of the MAC: random transmit frames beside received
  good, long, bad-check, runt and fragment frames. Assumes gigabit mode.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_tsm_mac
  import tsm_pkg::*;
;
  logic           clk_in, reset_n_in, rx_clk_in, spd, avail, rd, done, svld, gbit;
  tsm_tx_byte_t   head;
  tsm_gmii_tx_t   gtx;
  tsm_gmii_rx_t   grx;
  tsm_rx_client_t cli;
  tsm_rx_stat_t   stv;
  logic [7:0]     tb_b [0:127];
  logic [7:0]     rb [0:127];
  logic           rgood;
  int             tlen, tidx, rn, sc, err_count, tests_run;

  tsm_mac uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .rx_clk_in(rx_clk_in),
    .speed_gbit_in(spd), .full_duplex_in(1'b1), .tx_clk_en_in(1'b1), .rx_clk_en_in(1'b1),
    .tx_fifo_avail_in(avail), .tx_fifo_head_in(head), .tx_fifo_rd_out(rd),
    .tx_done_out(done), .tx_abort_out(), .gmii_tx_out(gtx), .gmii_rx_in(grx),
    .col_in(1'b0), .crs_in(1'b0), .rx_client_out(cli), .rx_stat_out(stv),
    .rx_stat_vld_out(svld), .gbit_en_out(gbit));
  tsm_phy_model phy (.rx_clk_out(rx_clk_in), .gmii_out(grx));

  assign head = '{tb_b[tidx], tidx == tlen - 1};
  always @(posedge clk_in) begin
    if (rd === 1'b1) tidx <= tidx + 1;
    if (svld === 1'b1) sc <= sc + 1;
  end
  always @(posedge rx_clk_in) begin
    if (cli.wr === 1'b1) begin
      rb[rn] <= cli.data;
      rn <= rn + 1;
      if (cli.eof === 1'b1) rgood <= cli.good;
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    return c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tx_frame(input int n);
    logic [31:0] c;
    logic [7:0]  v;
    int          j, k;
    c = 32'hFFFFFFFF;
    j = 0;
    @(posedge clk_in);
    for (k = 0; k < n; k++) begin
      v = 8'($urandom);
      tb_b[k] <= v;
      c = crc_upd(c, v);
    end
    tlen <= n;
    tidx <= 0;
    avail <= 1'b1;
    for (k = 0; k < 300 && done !== 1'b1; k++) begin
      @(posedge clk_in);
      if (gtx.tx_en === 1'b1) begin
        v = j < 7 ? 8'h55 : j == 7 ? 8'hD5 : j < n + 8 ? tb_b[j-8] : 8'(~c >> (8 * (j - n - 8)));
        chk(gtx.txd, v);
        j++;
      end
    end
    avail <= 1'b0;
    chk(done, 1'b1);
    if (done !== 1'b1) tally_and_finish();
    chk(j, n + 12);
    chk(tidx, n);
    repeat (16) @(posedge clk_in);
  endtask

  task automatic rx_frame(input int n, input bit bad);
    logic [7:0]  f [0:127];
    logic [31:0] c;
    int          k, s;
    c = 32'hFFFFFFFF;
    for (k = 0; k < n - 4; k++) begin
      f[k] = k < 6 ? 8'hFF : 8'($urandom);
      c = crc_upd(c, f[k]);
    end
    for (k = 0; k < 4; k++) f[n-4+k] = 8'(~c >> (8 * k));
    if (bad) f[n-1] = ~f[n-1];
    rn = 0;
    s = sc;
    phy.send(f, n);
    repeat (40) @(posedge clk_in);
    chk(rn, n < 7 ? 0 : n - 4);
    for (k = 0; k < rn; k++) chk(rb[k], f[k]);
    if (n >= 7) chk(rgood, !bad && n >= 64);
    chk(sc - s, 1);
    chk(stv.byte_cnt, n);
    chk(stv.crc_ok, !bad);
    chk(stv.runt, n < 64);
    if (n >= 6) chk(stv.bcast, 1'b1);
  endtask

  initial begin
    reset_n_in = 1'b0;
    spd = 1'b1;
    avail = 1'b0;
    {tlen, tidx, rn, sc, err_count, tests_run} = '0;
    void'($urandom(32'h239C));
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    chk(gbit, 1'b1);
    fork
      for (int i = 0; i < 4; i++) tx_frame(i == 0 ? 1 : 2 + $urandom % 30);
      begin
        rx_frame(64, 0);
        rx_frame(65 + $urandom % 20, 0);
        rx_frame(64, 1);
        rx_frame(20, 0);
        rx_frame(5, 0);
      end
    join
    tally_and_finish();
  end
endmodule
`default_nettype wire
